// ==== shared/win_pkg.sv ====
package win_pkg;

  // Widths
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int CW = 12;
  localparam int PW = 12;
  localparam int SW = 4;

  // Sensor array, physical columns and lines
  localparam logic [CW-1:0] SENSOR_W  = 12'h800;
  localparam logic [CW-1:0] SENSOR_H  = 12'h440;
  localparam logic [CW-1:0] ZERO_C    = 12'h000;
  localparam int            BIN_SHIFT = 1;

  // Register offsets
  localparam logic [AW-1:0] A_LEFT   = 8'h00;
  localparam logic [AW-1:0] A_TOP    = 8'h04;
  localparam logic [AW-1:0] A_WIDTH  = 8'h08;
  localparam logic [AW-1:0] A_HEIGHT = 8'h0c;
  localparam logic [AW-1:0] A_CENTER = 8'h10;
  localparam logic [AW-1:0] A_UNIT   = 8'h14;
  localparam logic [AW-1:0] A_PSEL   = 8'h18;
  localparam logic [AW-1:0] A_RMLIM  = 8'h1c;
  localparam logic [AW-1:0] A_GAIN   = 8'h20;
  localparam logic [AW-1:0] A_EXPO   = 8'h24;
  localparam logic [AW-1:0] A_EFF    = 8'h28;
  localparam logic [AW-1:0] A_GEOM   = 8'h2c;

  // Field positions
  localparam int CTR_X_BIT  = 0;
  localparam int CTR_Y_BIT  = 1;
  localparam int COLOUR_BIT = 0;
  localparam int TAP_LSB    = 4;
  localparam int TAP_MSB    = 6;
  localparam int BINH_BIT   = 8;
  localparam int BINV_BIT   = 9;
  localparam int FLAG_BIT   = 0;

  // Gain code and exposure limits
  localparam logic [8:0]  GAIN_MIN     = 9'h021;
  localparam logic [8:0]  GAIN_MAX     = 9'h1ff;
  localparam logic [8:0]  GAIN_EXT_MIN = 9'h000;
  localparam logic [8:0]  GAIN_RST     = 9'h021;
  localparam logic [23:0] EXPO_MIN_US     = 24'h00000a;
  localparam logic [23:0] EXPO_EXT_MIN_US = 24'h000002;
  localparam logic [23:0] EXPO_MAX_US     = 24'h0f4240;
  localparam logic [23:0] EXPO_RST_US     = 24'h001388;

  typedef enum logic [2:0] {
    TAP_2  = 3'b000,
    TAP_3  = 3'b001,
    TAP_4  = 3'b010,
    TAP_6  = 3'b011,
    TAP_8  = 3'b100,
    TAP_10 = 3'b101
  } tap_t;

  typedef enum logic [0:0] {
    SEL_GAIN = 1'b0,
    SEL_EXPO = 1'b1
  } psel_t;

  // Column step per tap geometry; colour three-tap needs whole colour pairs
  function automatic logic [SW-1:0] x_step(input tap_t tap, input logic colour);
    case (tap)
      TAP_2:   return 4'h2;
      TAP_3:   return colour ? 4'h6 : 4'h3;
      TAP_4:   return 4'h4;
      TAP_6:   return 4'h6;
      TAP_8:   return 4'h8;
      TAP_10:  return 4'ha;
      default: return 4'h2;
    endcase
  endfunction

  function automatic logic [SW-1:0] y_step(input logic colour);
    return colour ? 4'h2 : 4'h1;
  endfunction

  // Round down onto the step grid; constant divisors only
  function automatic logic [CW-1:0] snap(input logic [CW-1:0] v, input logic [SW-1:0] s);
    case (s)
      4'h2:    return {v[CW-1:1], 1'b0};
      4'h3:    return (v / 12'h003) * 12'h003;
      4'h4:    return {v[CW-1:2], 2'b00};
      4'h6:    return (v / 12'h006) * 12'h006;
      4'h8:    return {v[CW-1:3], 3'b000};
      4'ha:    return (v / 12'h00a) * 12'h00a;
      default: return v;
    endcase
  endfunction

endpackage

// ==== shared/axis_if.sv ====
`timescale 1ns/1ps
interface axis_if;
  logic [win_pkg::CW-1:0] lim;
  logic [win_pkg::CW-1:0] len;
  logic [win_pkg::CW-1:0] org;
  logic [win_pkg::SW-1:0] step;
  logic                   center;
  logic [win_pkg::CW-1:0] eff;

  modport ctl  (output lim, output len, output org, output step, output center, input  eff);
  modport calc (input  lim, input  len, input  org, input  step, input  center, output eff);
endinterface

// ==== rtl/win_origin.sv ====
`timescale 1ns/1ps
module win_origin (
  // Clock and reset
  input  logic sys_clk,
  input  logic rst_b,
  // One axis of the window
  axis_if.calc ax
);

  logic [win_pkg::CW-1:0] slack;
  logic [win_pkg::CW-1:0] centred;
  logic [win_pkg::CW-1:0] fitted;
  logic [win_pkg::CW-1:0] nxt_eff;
  logic [win_pkg::CW-1:0] eff_ff;

  assign slack   = ax.lim - ax.len;
  assign centred = win_pkg::snap(slack >> 1, ax.step); // RQ20
  // Origin pulled back so origin plus length never runs off the array
  assign fitted  = (ax.org > slack) ? win_pkg::snap(slack, ax.step) : ax.org; // RQ10 RQ11
  assign nxt_eff = ax.center ? centred : fitted; // RQ7 RQ8

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      eff_ff <= win_pkg::ZERO_C;
    end else begin
      eff_ff <= nxt_eff;
    end
  end

  assign ax.eff = eff_ff;

endmodule // win_origin

// ==== rtl/readout_window.sv ====
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: Extended gain range drops only minimum to zero
// RQ2: Extended exposure range allows two microsecond minimum
// RQ3: Selector targets only gain or exposure time
// RQ4: Software selects target, then sets flag
// RQ5: Column and row zero at top left
// RQ6: Only pixels inside window leave the block
// RQ7: Horizontal centering overrides programmed left column
// RQ8: Vertical centering overrides programmed top row
// RQ9: Reset leaves window at full sensor size
// RQ10: Left column plus width within sensor width
// RQ11: Top row plus height within sensor height
// RQ12: Monochrome rows and height step one line
// RQ13: Colour rows and height step two lines
// RQ14: Monochrome column step follows tap geometry
// RQ15: Colour column step, three-tap becomes six
// RQ16: Binning makes window units virtual columns, lines
// RQ17: Software writes left, top, width, height order
// RQ18: Gain code spans 33 to 511 normally
// RQ19: Illegal writes clamp down onto step grid
// RQ20: Centred origin is half slack, snapped down
module readout_window (
  // Clock and reset
  input  logic                      sys_clk,
  input  logic                      rst_b,
  // Register port
  input  logic [win_pkg::AW-1:0]    reg_addr,
  input  logic [win_pkg::DW-1:0]    reg_wdata,
  input  logic                      reg_wr,
  input  logic                      reg_rd,
  output logic [win_pkg::DW-1:0]    reg_rdata,
  // Pixel stream from the array
  input  logic                      pix_in_valid,
  input  logic                      pix_in_sof,
  input  logic                      pix_in_sol,
  input  logic [win_pkg::PW-1:0]    pix_in_data,
  // Pixel stream inside the window
  output logic                      pix_out_valid,
  output logic                      pix_out_sof,
  output logic                      pix_out_sol,
  output logic [win_pkg::PW-1:0]    pix_out_data,
  // Limited settings to the sensor front end
  output logic [8:0]                gain_code,
  output logic [23:0]               expo_us
);

  localparam int CW = win_pkg::CW;
  localparam int SW = win_pkg::SW;

  function automatic logic hit(input logic [win_pkg::AW-1:0] a, input logic [win_pkg::AW-1:0] off);
    return a == off;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Unit configuration

  logic                   colour_ff;
  win_pkg::tap_t          tap_ff;
  logic                   binh_ff;
  logic                   binv_ff;
  logic                   ctr_x_ff;
  logic                   ctr_y_ff;
  logic                   wr_unit;
  logic                   wr_center;
  logic                   tap_ok;
  logic [CW-1:0]          lim   [2];
  logic [SW-1:0]          step  [2];
  logic                   ctr   [2];
  logic [CW-1:0]          org_q [2];
  logic [CW-1:0]          len_q [2];
  logic [CW-1:0]          eff_q [2];

  assign wr_unit   = reg_wr & hit(reg_addr, win_pkg::A_UNIT);
  assign wr_center = reg_wr & hit(reg_addr, win_pkg::A_CENTER);
  assign tap_ok    = reg_wdata[win_pkg::TAP_MSB:win_pkg::TAP_LSB] <= win_pkg::TAP_10;

  // Binned readout shrinks the array seen by the window
  assign lim[0]  = binh_ff ? (win_pkg::SENSOR_W >> win_pkg::BIN_SHIFT) : win_pkg::SENSOR_W; // RQ16
  assign lim[1]  = binv_ff ? (win_pkg::SENSOR_H >> win_pkg::BIN_SHIFT) : win_pkg::SENSOR_H; // RQ16
  assign step[0] = win_pkg::x_step(tap_ff, colour_ff); // RQ14 RQ15
  assign step[1] = win_pkg::y_step(colour_ff); // RQ12 RQ13
  assign ctr[0]  = ctr_x_ff;
  assign ctr[1]  = ctr_y_ff;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      colour_ff <= 1'b0;
      tap_ff    <= win_pkg::TAP_2;
      binh_ff   <= 1'b0;
      binv_ff   <= 1'b0;
    end else if (wr_unit) begin
      colour_ff <= reg_wdata[win_pkg::COLOUR_BIT];
      binh_ff   <= reg_wdata[win_pkg::BINH_BIT];
      binv_ff   <= reg_wdata[win_pkg::BINV_BIT];
      if (tap_ok) begin
        tap_ff <= win_pkg::tap_t'(reg_wdata[win_pkg::TAP_MSB:win_pkg::TAP_LSB]);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctr_x_ff <= 1'b0;
      ctr_y_ff <= 1'b0;
    end else if (wr_center) begin
      ctr_x_ff <= reg_wdata[win_pkg::CTR_X_BIT];
      ctr_y_ff <= reg_wdata[win_pkg::CTR_Y_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window origin and size, one pass per axis

  logic          wide_hi;
  logic [CW-1:0] wval;

  assign wide_hi = |reg_wdata[win_pkg::DW-1:CW];
  assign wval    = wide_hi ? {CW{1'b1}} : reg_wdata[CW-1:0];

  for (genvar g = 0; g < 2; g++) begin : g_axis
    localparam logic [win_pkg::AW-1:0] ORG_A = (g == 0) ? win_pkg::A_LEFT  : win_pkg::A_TOP;
    localparam logic [win_pkg::AW-1:0] LEN_A = (g == 0) ? win_pkg::A_WIDTH : win_pkg::A_HEIGHT;
    localparam logic [CW-1:0]          FULL  = (g == 0) ? win_pkg::SENSOR_W : win_pkg::SENSOR_H;
    localparam int                     BIN_B = (g == 0) ? win_pkg::BINH_BIT : win_pkg::BINV_BIT;

    logic          wr_org;
    logic          wr_len;
    logic [CW-1:0] step_c;
    logic [CW-1:0] max_org;
    logic [CW-1:0] org_new;
    logic [CW-1:0] room;
    logic [CW-1:0] avail;
    logic [CW-1:0] len_snap;
    logic [CW-1:0] len_new;
    logic [CW-1:0] len_fit;
    logic [CW-1:0] org_ff;
    logic [CW-1:0] len_ff;
    logic [CW-1:0] nxt_org;
    logic [CW-1:0] nxt_len;
    logic [CW-1:0] lim_new;

    axis_if ax ();

    assign wr_org  = reg_wr & hit(reg_addr, ORG_A);
    assign wr_len  = reg_wr & hit(reg_addr, LEN_A);
    assign step_c  = {{(CW-SW){1'b0}}, step[g]};
    assign max_org = lim[g] - step_c;
    // Origin snaps down and leaves room for at least one step
    assign org_new = win_pkg::snap((wval > max_org) ? max_org : wval, step[g]); // RQ19
    // A new origin trims the size so the pair still fits
    assign room    = lim[g] - org_new;
    assign len_fit = (len_ff > room) ? win_pkg::snap(room, step[g]) : len_ff; // RQ10 RQ11
    // Centering frees the size from the programmed origin
    assign avail    = ctr[g] ? lim[g] : lim[g] - org_ff;
    assign len_snap = win_pkg::snap((wval > avail) ? avail : wval, step[g]); // RQ19
    assign len_new  = (len_snap == win_pkg::ZERO_C) ? step_c : len_snap;

    // A unit change re-opens the full array, as old values may be off grid
    // The limit register still holds the old binning on that edge, so take it from the write
    assign lim_new = reg_wdata[BIN_B] ? (FULL >> win_pkg::BIN_SHIFT) : FULL; // RQ16
    assign nxt_org = wr_unit ? win_pkg::ZERO_C : (wr_org ? org_new : org_ff);
    assign nxt_len = wr_unit ? lim_new : (wr_org ? len_fit : (wr_len ? len_new : len_ff));

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        org_ff <= win_pkg::ZERO_C; // RQ9
        len_ff <= FULL; // RQ9
      end else begin
        org_ff <= nxt_org;
        len_ff <= nxt_len;
      end
    end

    assign ax.lim    = lim[g];
    assign ax.len    = len_ff;
    assign ax.org    = org_ff;
    assign ax.step   = step[g];
    assign ax.center = ctr[g];

    win_origin u_origin (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .ax      (ax.calc)
    );

    assign org_q[g] = org_ff;
    assign len_q[g] = len_ff;
    assign eff_q[g] = ax.eff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Extended range for gain and exposure

  win_pkg::psel_t psel_ff;
  logic           ext_gain_ff;
  logic           ext_expo_ff;
  logic [8:0]     gain_ff;
  logic [23:0]    expo_ff;
  logic           wr_psel;
  logic           wr_rmlim;
  logic           wr_gain;
  logic           wr_expo;
  logic           psel_ok;
  logic           flag_w;
  logic           nxt_ext_gain;
  logic           nxt_ext_expo;
  logic [8:0]     gain_min;
  logic [23:0]    expo_min;
  logic [8:0]     gain_req;
  logic [23:0]    expo_req;
  logic [8:0]     gain_new;
  logic [23:0]    expo_new;
  logic [8:0]     nxt_gain;
  logic [23:0]    nxt_expo;

  assign wr_psel  = reg_wr & hit(reg_addr, win_pkg::A_PSEL);
  assign wr_rmlim = reg_wr & hit(reg_addr, win_pkg::A_RMLIM);
  assign wr_gain  = reg_wr & hit(reg_addr, win_pkg::A_GAIN);
  assign wr_expo  = reg_wr & hit(reg_addr, win_pkg::A_EXPO);
  // Only two targets exist; any other code leaves the selector as is
  assign psel_ok  = ~|reg_wdata[win_pkg::DW-1:1]; // RQ3
  assign flag_w   = reg_wdata[win_pkg::FLAG_BIT];

  // The flag lands on whichever target is selected now
  assign nxt_ext_gain = (wr_rmlim && psel_ff == win_pkg::SEL_GAIN) ? flag_w : ext_gain_ff; // RQ4
  assign nxt_ext_expo = (wr_rmlim && psel_ff == win_pkg::SEL_EXPO) ? flag_w : ext_expo_ff; // RQ4

  // Only the floor moves; the ceiling of 511 stays
  assign gain_min = nxt_ext_gain ? win_pkg::GAIN_EXT_MIN : win_pkg::GAIN_MIN; // RQ1 RQ18
  assign expo_min = nxt_ext_expo ? win_pkg::EXPO_EXT_MIN_US : win_pkg::EXPO_MIN_US; // RQ2

  assign gain_req = (|reg_wdata[win_pkg::DW-1:9]) ? win_pkg::GAIN_MAX : reg_wdata[8:0];
  assign expo_req = (|reg_wdata[win_pkg::DW-1:24]) ? win_pkg::EXPO_MAX_US : reg_wdata[23:0];
  assign gain_new = wr_gain ? gain_req : gain_ff;
  assign expo_new = wr_expo ? expo_req : expo_ff;

  // Dropping the flag pulls a low setting back up to the factory floor
  assign nxt_gain = (gain_new < gain_min) ? gain_min :
                    (gain_new > win_pkg::GAIN_MAX) ? win_pkg::GAIN_MAX : gain_new; // RQ18
  assign nxt_expo = (expo_new < expo_min) ? expo_min :
                    (expo_new > win_pkg::EXPO_MAX_US) ? win_pkg::EXPO_MAX_US : expo_new; // RQ2

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      psel_ff <= win_pkg::SEL_GAIN;
    end else if (wr_psel && psel_ok) begin
      psel_ff <= win_pkg::psel_t'(reg_wdata[0]); // RQ3
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_gain_ff <= 1'b0;
      ext_expo_ff <= 1'b0;
      gain_ff     <= win_pkg::GAIN_RST;
      expo_ff     <= win_pkg::EXPO_RST_US;
    end else begin
      ext_gain_ff <= nxt_ext_gain;
      ext_expo_ff <= nxt_ext_expo;
      gain_ff     <= nxt_gain;
      expo_ff     <= nxt_expo;
    end
  end

  assign gain_code = gain_ff;
  assign expo_us   = expo_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pixel gating

  logic [CW-1:0] col_ff;
  logic [CW-1:0] row_ff;
  logic [CW-1:0] cur_col;
  logic [CW-1:0] cur_row;
  logic [CW-1:0] fx_ff;
  logic [CW-1:0] fy_ff;
  logic [CW-1:0] fw_ff;
  logic [CW-1:0] fh_ff;
  logic [CW-1:0] use_x;
  logic [CW-1:0] use_y;
  logic [CW-1:0] use_w;
  logic [CW-1:0] use_h;
  logic          frame_go;
  logic          in_x;
  logic          in_y;
  logic          in_win;
  logic          out_valid_ff;
  logic          out_sof_ff;
  logic          out_sol_ff;
  logic [win_pkg::PW-1:0] out_data_ff;

  // Counters start at the top left corner of the array
  assign cur_col = (pix_in_sof | pix_in_sol) ? win_pkg::ZERO_C : col_ff + 12'h001; // RQ5
  assign cur_row = pix_in_sof ? win_pkg::ZERO_C : (pix_in_sol ? row_ff + 12'h001 : row_ff); // RQ5

  // Window is frozen at frame start so a mid-frame write cannot tear the image
  assign frame_go = pix_in_valid & pix_in_sof;
  assign use_x    = frame_go ? eff_q[0] : fx_ff;
  assign use_y    = frame_go ? eff_q[1] : fy_ff;
  assign use_w    = frame_go ? len_q[0] : fw_ff;
  assign use_h    = frame_go ? len_q[1] : fh_ff;

  assign in_x   = (cur_col >= use_x) && ({1'b0, cur_col} < {1'b0, use_x} + {1'b0, use_w});
  assign in_y   = (cur_row >= use_y) && ({1'b0, cur_row} < {1'b0, use_y} + {1'b0, use_h});
  assign in_win = pix_in_valid & in_x & in_y; // RQ6

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      col_ff <= win_pkg::ZERO_C;
      row_ff <= win_pkg::ZERO_C;
    end else if (pix_in_valid) begin
      col_ff <= cur_col;
      row_ff <= cur_row;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fx_ff <= win_pkg::ZERO_C;
      fy_ff <= win_pkg::ZERO_C;
      fw_ff <= win_pkg::SENSOR_W;
      fh_ff <= win_pkg::SENSOR_H;
    end else if (frame_go) begin
      fx_ff <= use_x;
      fy_ff <= use_y;
      fw_ff <= use_w;
      fh_ff <= use_h;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid_ff <= 1'b0;
      out_sof_ff   <= 1'b0;
      out_sol_ff   <= 1'b0;
      out_data_ff  <= {win_pkg::PW{1'b0}};
    end else begin
      out_valid_ff <= in_win; // RQ6
      out_sof_ff   <= in_win && cur_col == use_x && cur_row == use_y;
      out_sol_ff   <= in_win && cur_col == use_x;
      if (in_win) begin
        out_data_ff <= pix_in_data;
      end
    end
  end

  assign pix_out_valid = out_valid_ff;
  assign pix_out_sof   = out_sof_ff;
  assign pix_out_sol   = out_sol_ff;
  assign pix_out_data  = out_data_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Register read back

  logic [win_pkg::DW-1:0] rd_mux;
  logic [win_pkg::DW-1:0] rdata_ff;

  assign rd_mux =
    hit(reg_addr, win_pkg::A_LEFT)   ? {20'h00000, org_q[0]} :
    hit(reg_addr, win_pkg::A_TOP)    ? {20'h00000, org_q[1]} :
    hit(reg_addr, win_pkg::A_WIDTH)  ? {20'h00000, len_q[0]} :
    hit(reg_addr, win_pkg::A_HEIGHT) ? {20'h00000, len_q[1]} :
    hit(reg_addr, win_pkg::A_CENTER) ? {30'h00000000, ctr_y_ff, ctr_x_ff} :
    hit(reg_addr, win_pkg::A_UNIT)   ? {22'h000000, binv_ff, binh_ff, 1'b0, tap_ff, 3'h0, colour_ff} :
    hit(reg_addr, win_pkg::A_PSEL)   ? {31'h00000000, psel_ff} :
    hit(reg_addr, win_pkg::A_RMLIM)  ? {31'h00000000, (psel_ff == win_pkg::SEL_GAIN) ? ext_gain_ff : ext_expo_ff} :
    hit(reg_addr, win_pkg::A_GAIN)   ? {23'h000000, gain_ff} :
    hit(reg_addr, win_pkg::A_EXPO)   ? {8'h00, expo_ff} :
    hit(reg_addr, win_pkg::A_EFF)    ? {4'h0, eff_q[1], 4'h0, eff_q[0]} :
    hit(reg_addr, win_pkg::A_GEOM)   ? {step[1], step[0], lim[1], lim[0]} :
                                       32'h00000000;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 32'h00000000;
    end else if (reg_rd) begin
      rdata_ff <= rd_mux;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule // readout_window

// ==== verif/readout_window_checker.sv ====
`timescale 1ns/1ps
module readout_window_checker (
  // Clock and reset
  input logic        sys_clk,
  input logic        rst_b,
  // Register port
  input logic [7:0]  reg_addr,
  input logic [31:0] reg_wdata,
  input logic        reg_wr,
  // Pixel streams
  input logic        pix_in_valid,
  input logic [11:0] pix_in_data,
  input logic        pix_out_valid,
  input logic        pix_out_sof,
  input logic        pix_out_sol,
  input logic [11:0] pix_out_data,
  // Limited settings
  input logic [8:0]  gain_code,
  input logic [23:0] expo_us
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  // Flags as software left them; a refused selector value changes nothing
  logic sel_ff;
  logic gext_ff;
  logic eext_ff;
  wire  sel_wr = reg_wr && reg_addr == 8'h18 && reg_wdata[31:1] == 31'h0;
  wire  lim_wr = reg_wr && reg_addr == 8'h1c;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_ff  <= 1'b0;
      gext_ff <= 1'b0;
      eext_ff <= 1'b0;
    end else begin
      if (sel_wr) sel_ff <= reg_wdata[0];
      if (lim_wr && !sel_ff) gext_ff <= reg_wdata[0];
      if (lim_wr && sel_ff) eext_ff <= reg_wdata[0];
    end
  end
  ////////////////////////////////////////////////////////////////
  // Legal gain codes pass through untouched
  property gain_pass_p;
    (reg_wr && reg_addr == 8'h20 && reg_wdata >= 32'h21 && reg_wdata <= 32'h1ff)
      |=> gain_code == $past(reg_wdata[8:0]);
  endproperty
  out_has_source_a: assert property (pix_out_valid |-> $past(pix_in_valid))
    else $error("window pixel without an input pixel");
  out_data_copy_a: assert property (pix_out_valid |-> pix_out_data == $past(pix_in_data))
    else $error("window pixel data differs from input");
  out_data_hold_a: assert property (!pix_out_valid |-> $stable(pix_out_data))
    else $error("pixel data moved outside the window");
  frame_start_a: assert property (pix_out_sof |-> pix_out_valid && pix_out_sol)
    else $error("frame start without line start");
  line_start_a: assert property (pix_out_sol |-> pix_out_valid)
    else $error("line start without a pixel");
  // Two edges of slack cover the flag write and the registered output
  gain_floor_a: assert property (!(gext_ff || $past(gext_ff) || $past(gext_ff, 2)) |-> gain_code >= 9'h021)
    else $error("gain below floor with limits kept");
  expo_floor_a: assert property (!(eext_ff || $past(eext_ff) || $past(eext_ff, 2)) |-> expo_us >= 24'h00000a)
    else $error("exposure below floor with limits kept");
  expo_range_a: assert property (expo_us >= 24'h000002 && expo_us <= 24'h0f4240)
    else $error("exposure outside extended range");
  gain_pass_a: assert property (gain_pass_p)
    else $error("legal gain code not applied");
  frame_seen_c: cover property (pix_out_sof);
  gain_ext_c: cover property (gext_ff && gain_code < 9'h021);
  expo_ext_c: cover property (eext_ff && expo_us < 24'h00000a);
endmodule // readout_window_checker

bind readout_window readout_window_checker u_chk (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
  .pix_in_valid, .pix_in_data, .pix_out_valid, .pix_out_sof, .pix_out_sol, .pix_out_data, .gain_code, .expo_us);

// ==== verif/pix_source.sv ====
`timescale 1ns/1ps
module pix_source (
  // Clock
  input  logic        sys_clk,
  // Frame request
  input  logic        go,
  input  logic [7:0]  ncols,
  input  logic [7:0]  nrows,
  output logic        busy,
  // Pixel stream to the window block
  output logic        pix_valid,
  output logic        pix_sof,
  output logic        pix_sol,
  output logic [11:0] pix_data
);
  initial begin
    busy      = 1'b0;
    pix_valid = 1'b0;
    pix_sof   = 1'b0;
    pix_sol   = 1'b0;
    pix_data  = 12'h5a5;
  end
  ////////////////////////////////////////////////////////////////
  // Data carries its own row and column, so every pixel names its origin
  always @(posedge sys_clk) begin
    if (go) begin
      busy <= 1'b1;
      for (int r = 0; r < nrows; r++) begin
        for (int c = 0; c < ncols; c++) begin
          pix_valid <= 1'b1;
          pix_sof   <= r == 0 && c == 0;
          pix_sol   <= c == 0;
          pix_data  <= {r[5:0], c[5:0]};
          @(posedge sys_clk);
        end
      end
      pix_valid <= 1'b0;
      pix_sof   <= 1'b0;
      pix_sol   <= 1'b0;
      // Idle data is not held, so a stale pixel cannot pass for a fresh one
      pix_data  <= ~pix_data;
      busy      <= 1'b0;
    end
  end
endmodule // pix_source

// ==== verif/readout_window_test.sv ====
`timescale 1ns/1ps
module readout_window_test;
  logic        sys_clk;
  logic        rst_b;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr, reg_rd;
  logic [31:0] reg_rdata;
  logic        pix_in_valid, pix_in_sof, pix_in_sol;
  logic [11:0] pix_in_data;
  logic        pix_out_valid, pix_out_sof, pix_out_sol;
  logic [11:0] pix_out_data;
  logic [8:0]  gain_code;
  logic [23:0] expo_us;
  logic        go, busy;
  logic [13:0] outq[$];
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          stp[12] = '{2, 3, 4, 6, 8, 10, 2, 6, 4, 6, 8, 10};

  readout_window DUT (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pix_in_valid,
    .pix_in_sof, .pix_in_sol, .pix_in_data, .pix_out_valid, .pix_out_sof, .pix_out_sol, .pix_out_data,
    .gain_code, .expo_us);
  pix_source SRC (.sys_clk, .go, .ncols(8'h18), .nrows(8'h08), .busy, .pix_valid(pix_in_valid),
    .pix_sof(pix_in_sof), .pix_sol(pix_in_sol), .pix_data(pix_in_data));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (pix_out_valid === 1'b1) outq.push_back({pix_out_sol, pix_out_sof, pix_out_data});
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, e);
  endtask
  // Geometry is latched at frame start, so the window is set before the frame
  task automatic frame(input int l, input int t, input int w, input int h);
    int i;
    outq = {};
    @(posedge sys_clk);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (2) @(posedge sys_clk);
    for (i = 0; i < 1000 && busy === 1'b1; i++) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
    chk(outq.size(), w * h);
    for (i = 0; i < outq.size(); i++)
      chk(outq[i], {i % w == 0, i == 0, 6'(t + i / w), 6'(l + i % w)});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    results();
  end
  initial begin
    rst_b     = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    go        = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h800);
    rd(8'h0c, 32'h440);
    rd(8'h20, 32'h21);
    rd(8'h24, 32'h1388);
    rd(8'h2c, 32'h12440800);
    rd(8'h30, 32'h0);
    chk({23'h0, gain_code}, 32'h21);
    frame(0, 0, 24, 8);
    $display("test reset done");
    wr(8'h00, 32'h4);
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h6);
    wr(8'h0c, 32'h3);
    frame(4, 2, 6, 3);
    wr(8'h08, 32'h7fe);
    rd(8'h08, 32'h7fc);
    wr(8'h0c, 32'h440);
    rd(8'h0c, 32'h43e);
    wr(8'h00, 32'h5);
    rd(8'h00, 32'h4);
    $display("test window done");
    for (int k = 0; k < 12; k++) begin
      wr(8'h14, 32'((k / 6) | ((k % 6) << 4)));
      wr(8'h00, 32'h3b);
      wr(8'h04, 32'h3);
      rd(8'h00, 32'(59 / stp[k] * stp[k]));
      rd(8'h04, k < 6 ? 32'h3 : 32'h2);
      rd(8'h2c, {k < 6 ? 4'h1 : 4'h2, 4'(stp[k]), 24'h440800});
    end
    wr(8'h14, 32'h300);
    rd(8'h2c, 32'h12220400);
    rd(8'h08, 32'h400);
    $display("test steps done");
    wr(8'h14, 32'h0);
    wr(8'h00, 32'h10);
    wr(8'h04, 32'h8);
    wr(8'h08, 32'h102);
    wr(8'h0c, 32'h41);
    wr(8'h10, 32'h3);
    rd(8'h28, 32'h01ff037e);
    wr(8'h10, 32'h1);
    rd(8'h28, 32'h0008037e);
    wr(8'h10, 32'h2);
    rd(8'h28, 32'h01ff0010);
    $display("test centering done");
    wr(8'h20, 32'h5);
    rd(8'h20, 32'h21);
    wr(8'h18, 32'h0);
    wr(8'h1c, 32'h1);
    wr(8'h20, 32'h5);
    rd(8'h20, 32'h5);
    chk({23'h0, gain_code}, 32'h5);
    wr(8'h20, 32'h1ff);
    rd(8'h20, 32'h1ff);
    wr(8'h18, 32'h2);
    rd(8'h18, 32'h0);
    wr(8'h18, 32'h1);
    rd(8'h1c, 32'h0);
    wr(8'h24, 32'h1);
    rd(8'h24, 32'ha);
    wr(8'h1c, 32'h1);
    wr(8'h24, 32'h1);
    rd(8'h24, 32'h2);
    chk({8'h0, expo_us}, 32'h2);
    wr(8'h18, 32'h0);
    rd(8'h1c, 32'h1);
    wr(8'h20, 32'h5);
    wr(8'h1c, 32'h0);
    rd(8'h20, 32'h21);
    $display("test limits done");
    results();
  end
endmodule // readout_window_test
